/* File: scd_supervisor.sv */
// scan cycle supervisor: minimum period, watch limit, servicing watch, duration records
// assumes scan_done pulses once at the end of each program scan and service_busy
// is high for the length of each peripheral servicing cycle
`timescale 1ns/100ps
module scd_supervisor
  import scd_pkg::*;
#(
  parameter int unsigned TICK_CLKS_P = TICK_CLKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // setup and status word access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // program scan and servicing
  input wire logic scan_done,
  input wire logic parallel_mode,
  input wire logic service_busy,
  output logic scan_start,
  output logic halt,
  output logic cycle_overrun_flag,
  output logic service_overrun_flag
);
  typedef struct packed {
    scd_state_e st;
    logic scan_start;
    logic halt;
    logic cyc_flag;
    logic svc_flag;
    logic [15:0] min_set;
    logic [15:0] watch_set;
    logic [31:0] max_d;
    logic [31:0] pres_d;
    logic [31:0] svc_d;
    logic svc_q;
    logic push;
    logic [15:0] rdata;
  } scd_main_s;

  localparam scd_main_s MAIN_RST = '{
    st: SCD_LAUNCH,
    scan_start: 1'b0,
    halt: 1'b0,
    cyc_flag: 1'b0,
    svc_flag: 1'b0,
    min_set: MIN_CYCLE_RST,
    watch_set: WATCH_RST,
    max_d: 32'h00000000,
    pres_d: 32'h00000000,
    svc_d: 32'h00000000,
    svc_q: 1'b0,
    push: 1'b0,
    rdata: 16'h0000
  };

  scd_main_s r;
  scd_main_s next_r;

  scd_tmr_if cyc_if ();
  scd_tmr_if svc_if ();

  logic [31:0] mean_d;
  logic [31:0] cyc_cnt;
  logic [31:0] svc_cnt;
  logic [31:0] min_lim;
  logic [31:0] watch_lim;

  // cycle timer restarts at each launch
  assign cyc_if.clr = (r.st == SCD_LAUNCH); // RULE_14
  // servicing timer runs only while a servicing cycle is open
  assign svc_if.clr = !r.svc_q;
  assign cyc_cnt = cyc_if.count;
  assign svc_cnt = svc_if.count;
  assign min_lim = scd_min_ticks(r.min_set); // RULE_01
  assign watch_lim = scd_watch_ticks(r.watch_set); // RULE_05 RULE_06

  scd_tick_timer #(
    .TICK_CLKS_P(TICK_CLKS_P)
  ) u_cyc_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .t(cyc_if.tmr)
  );

  scd_tick_timer #(
    .TICK_CLKS_P(TICK_CLKS_P)
  ) u_svc_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .t(svc_if.tmr)
  );

  scd_avg8 u_avg (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .push(r.push),
    .din(r.pres_d),
    .mean(mean_d)
  );

  always_comb begin
    next_r = r;
    next_r.scan_start = 1'b0;
    next_r.push = 1'b0;
    next_r.svc_q = service_busy;

    // setup words
    if (reg_wr) begin
      case (reg_addr)
        OFS_MIN_CYCLE: begin
          next_r.min_set = reg_wdata; // RULE_01
        end
        OFS_WATCH: begin
          next_r.watch_set = reg_wdata; // RULE_05
        end
        default: begin
        end
      endcase
    end

    // scan sequencing
    case (r.st)
      SCD_LAUNCH: begin
        next_r.scan_start = 1'b1;
        next_r.st = SCD_EXEC;
      end
      SCD_EXEC: begin
        if (cyc_cnt > watch_lim) begin
          next_r.cyc_flag = 1'b1; // RULE_04
          next_r.halt = 1'b1; // RULE_04
          next_r.st = SCD_HALT;
        end else if (scan_done) begin
          // parallel mode closes the record on execution time alone
          if (parallel_mode) begin
            next_r.pres_d = cyc_cnt; // RULE_12 RULE_08 RULE_09
            next_r.push = 1'b1; // RULE_11
            if (cyc_cnt > r.max_d) begin
              next_r.max_d = cyc_cnt; // RULE_08
            end
          end
          next_r.st = SCD_PAD;
        end
      end
      SCD_PAD: begin
        // pad until the minimum, or pass at once when already past it
        if (cyc_cnt >= min_lim) begin // RULE_02 RULE_03
          if (!parallel_mode) begin
            next_r.pres_d = cyc_cnt; // RULE_08 RULE_09
            next_r.push = 1'b1; // RULE_11
            if (cyc_cnt > r.max_d) begin
              next_r.max_d = cyc_cnt; // RULE_08
            end
          end
          next_r.st = SCD_LAUNCH;
        end
      end
      SCD_HALT: begin
        next_r.st = SCD_HALT; // RULE_15
      end
      default: begin
        next_r.st = SCD_HALT;
      end
    endcase

    // servicing watch overrides the scan sequence
    if (r.svc_q && (svc_cnt > SVC_LIMIT_TICKS)) begin
      next_r.svc_flag = 1'b1; // RULE_07
      next_r.halt = 1'b1; // RULE_07
      next_r.scan_start = 1'b0;
      next_r.st = SCD_HALT;
    end
    if (r.svc_q && !service_busy && parallel_mode) begin
      next_r.svc_d = svc_cnt; // RULE_13
    end

    // status words read back one cycle after the address
    case (reg_addr)
      OFS_MIN_CYCLE: next_r.rdata = r.min_set;
      OFS_WATCH: next_r.rdata = r.watch_set;
      OFS_MAX_LO: next_r.rdata = r.max_d[15:0];
      OFS_MAX_HI: next_r.rdata = r.max_d[31:16];
      OFS_PRES_LO: next_r.rdata = r.pres_d[15:0];
      OFS_PRES_HI: next_r.rdata = r.pres_d[31:16];
      OFS_SVC_LO: next_r.rdata = r.svc_d[15:0];
      OFS_SVC_HI: next_r.rdata = r.svc_d[31:16];
      OFS_MEAN_LO: next_r.rdata = mean_d[15:0]; // RULE_11
      OFS_MEAN_HI: next_r.rdata = mean_d[31:16]; // RULE_11
      default: next_r.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= MAIN_RST; // RULE_14
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign scan_start = r.scan_start;
  assign halt = r.halt;
  assign cycle_overrun_flag = r.cyc_flag;
  assign service_overrun_flag = r.svc_flag;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence pad_short_s;
    ce && r.st == SCD_PAD && cyc_cnt < min_lim;
  endsequence

  sequence pad_done_s;
    ce && r.st == SCD_PAD && cyc_cnt >= min_lim;
  endsequence

  sequence exec_end_par_s;
    ce && r.st == SCD_EXEC && scan_done && parallel_mode && cyc_cnt <= watch_lim;
  endsequence

  sequence watch_over_s;
    ce && r.st == SCD_EXEC && cyc_cnt > watch_lim;
  endsequence

  sequence svc_over_s;
    ce && r.svc_q && svc_cnt > SVC_LIMIT_TICKS;
  endsequence

  no_min_pass_a: assert property ( // RULE_01
    ce && r.st == SCD_PAD && r.min_set == 16'h0000 && !r.svc_q |=> r.st == SCD_LAUNCH
  ) else $error("zero minimum code still padded the cycle");

  pad_hold_a: assert property ( // RULE_02
    pad_short_s |=> !scan_start && r.st != SCD_LAUNCH
  ) else $error("next scan launched before the minimum elapsed");

  no_extra_pad_a: assert property ( // RULE_03
    pad_done_s |=> r.st inside {SCD_LAUNCH, SCD_HALT}
  ) else $error("cycle padded beyond the minimum");

  launch_pulse_a: assert property ( // RULE_02
    ce && r.st == SCD_LAUNCH && !(r.svc_q && svc_cnt > SVC_LIMIT_TICKS) |=> scan_start ##1 (!scan_start || !$past(ce))
  ) else $error("scan start is not a single pulse after launch");

  watch_trip_a: assert property ( // RULE_04
    watch_over_s |=> cycle_overrun_flag && halt && r.st == SCD_HALT
  ) else $error("watch limit overrun not flagged");

  watch_default_a: assert property ( // RULE_05
    !r.watch_set[WATCH_EN_BIT] |-> watch_lim == 32'h00002710
  ) else $error("default watch limit is not 1 s");

  watch_code_a: assert property ( // RULE_06
    r.watch_set[WATCH_EN_BIT] |-> watch_lim == 32'(r.watch_set[14:0]) * 32'h00000064
  ) else $error("programmed watch limit misscaled");

  svc_trip_a: assert property ( // RULE_07
    svc_over_s |=> service_overrun_flag && halt ##1 !scan_start
  ) else $error("servicing overrun not flagged");

  max_ge_a: assert property ( // RULE_08
    r.push |-> r.max_d >= r.pres_d
  ) else $error("maximum below present duration");

  par_record_a: assert property ( // RULE_12
    exec_end_par_s |=> r.pres_d == $past(cyc_cnt) && r.push
  ) else $error("parallel mode did not record execution time");

  svc_store_a: assert property ( // RULE_13
    ce && r.svc_q && !service_busy && parallel_mode |=> r.svc_d == $past(svc_cnt)
  ) else $error("servicing duration not stored");

  start_clear_a: assert property ( // RULE_14
    scan_start |-> cyc_cnt == 32'h00000000
  ) else $error("cycle timer not cleared at cycle start");

  // a second, different overrun may still join a flag that is already set
  flag_sticky_a: assert property ( // RULE_15
    cycle_overrun_flag || service_overrun_flag |=> halt &&
      (cycle_overrun_flag || !$past(cycle_overrun_flag)) && (service_overrun_flag || !$past(service_overrun_flag))
  ) else $error("overrun flag or halt released before reset");

  halt_quiet_a: assert property ( // RULE_15
    halt |-> !scan_start
  ) else $error("scan start issued while halted");

  present_rec_a: assert property ( // RULE_08 RULE_09
    pad_done_s ##0 !parallel_mode |=> r.pres_d == $past(cyc_cnt) && r.push
  ) else $error("present duration not recorded at cycle end");

  watch_quiet_a: assert property ( // RULE_04
    ce && !cycle_overrun_flag && !(r.st == SCD_EXEC && cyc_cnt > watch_lim) |=> !cycle_overrun_flag
  ) else $error("cycle overrun flagged within the watch limit");

  svc_quiet_a: assert property ( // RULE_07
    ce && !service_overrun_flag && !(r.svc_q && svc_cnt > SVC_LIMIT_TICKS) |=> !service_overrun_flag
  ) else $error("servicing overrun flagged within the limit");

  freeze_hold_a: assert property ( // RULE_14
    !ce |=> $stable(r) && $stable(cyc_cnt) && $stable(svc_cnt) && $stable(mean_d)
  ) else $error("state moved while the clock enable was low");
endmodule : scd_supervisor

/* File: scd_pkg.sv */
// constants, register map, states and decoders for the scan cycle supervisor
// assumes a 200 MHz clk_sys and 16-bit setup and status words addressed by word
// Overview of operation
// [RULE_01] The minimum cycle word takes codes 0001 to 7D00 for 1 to 32,000 ms in 1 ms steps, and 0000 means no minimum.
// [RULE_02] With a minimum set, the next scan is held off until the minimum has elapsed, giving a fixed period.
// [RULE_03] A scan longer than the minimum gets no padding, so that cycle's period follows its real length.
// [RULE_04] A cycle longer than the watch limit sets the cycle overrun flag and halts operation. Checked only while the scan executes, not in padding.
// [RULE_05] Bit 15 of the watch word picks the 1 s default limit when 0 and the limit in bits 0 to 14 when 1.
// [RULE_06] The programmed watch limit is a code 001 to FA0 for 10 to 40,000 ms in 10 ms steps.
// [RULE_07] A peripheral servicing cycle longer than 2.0 s sets the service overrun flag and halts operation.
// [RULE_08] At each cycle end both the running maximum and the present cycle duration are updated.
// [RULE_09] Each recorded duration is a 32-bit unsigned binary count.
// [RULE_10] Recorded durations count 0.1 ms units over the full range 0 to FFFF FFFF.
// [RULE_11] The mean of the last 8 completed cycles is readable.
// [RULE_12] In parallel processing mode the cycle duration used everywhere is the program execution time only.
// [RULE_13] In parallel processing mode each servicing cycle's duration is stored in its own status word.
// [RULE_14] Durations come from a 0.1 ms tick counter cleared at each cycle start, and the maximum clears at reset.
// [RULE_15] An overrun flag and the halt it caused stay set until the next power-up reset.
package scd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS = 100000;
  localparam int unsigned TICK_CLKS = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_STEP_MS = 1;
  localparam int unsigned WATCH_STEP_MS = 10;
  localparam int unsigned WATCH_DEFAULT_MS = 1000;
  localparam int unsigned SVC_LIMIT_MS = 2000;
  localparam logic [31:0] MIN_STEP_TICKS = 32'(MIN_STEP_MS * 1000000 / TICK_NS);
  localparam logic [31:0] WATCH_STEP_TICKS = 32'(WATCH_STEP_MS * 1000000 / TICK_NS);
  localparam logic [31:0] WATCH_DEFAULT_TICKS = 32'(WATCH_DEFAULT_MS * 1000000 / TICK_NS);
  localparam logic [31:0] SVC_LIMIT_TICKS = 32'(SVC_LIMIT_MS * 1000000 / TICK_NS);
  localparam logic [31:0] DUR_MAX = 32'hFFFFFFFF;
  localparam int unsigned WATCH_EN_BIT = 15;
  localparam int unsigned PRE_W = 15;
  localparam int unsigned AVG_DEPTH = 8;
  localparam int unsigned AVG_SHIFT = 3;
  localparam int unsigned ADDR_W = 9;
  localparam logic [ADDR_W-1:0] OFS_MIN_CYCLE = 9'h0D0;
  localparam logic [ADDR_W-1:0] OFS_WATCH = 9'h0D1;
  localparam logic [ADDR_W-1:0] OFS_MAX_LO = 9'h106;
  localparam logic [ADDR_W-1:0] OFS_MAX_HI = 9'h107;
  localparam logic [ADDR_W-1:0] OFS_PRES_LO = 9'h108;
  localparam logic [ADDR_W-1:0] OFS_PRES_HI = 9'h109;
  localparam logic [ADDR_W-1:0] OFS_SVC_LO = 9'h10C;
  localparam logic [ADDR_W-1:0] OFS_SVC_HI = 9'h10D;
  localparam logic [ADDR_W-1:0] OFS_MEAN_LO = 9'h10E;
  localparam logic [ADDR_W-1:0] OFS_MEAN_HI = 9'h10F;
  localparam logic [15:0] MIN_CYCLE_RST = 16'h0000;
  localparam logic [15:0] WATCH_RST = 16'h0000;

  typedef enum logic [1:0] {SCD_LAUNCH, SCD_EXEC, SCD_PAD, SCD_HALT} scd_state_e;

  // code 0000 yields zero ticks, so the pad state passes at once
  function automatic logic [31:0] scd_min_ticks(input logic [15:0] w);
    return 32'(w) * MIN_STEP_TICKS;
  endfunction : scd_min_ticks

  function automatic logic [31:0] scd_watch_ticks(input logic [15:0] w);
    if (w[WATCH_EN_BIT]) begin
      return 32'(w[14:0]) * WATCH_STEP_TICKS;
    end
    return WATCH_DEFAULT_TICKS;
  endfunction : scd_watch_ticks
endpackage : scd_pkg

/* File: scd_tmr_if.sv */
// control and count of one 0.1 ms tick timer
// assumes both ends run on clk_sys
`timescale 1ns/100ps
interface scd_tmr_if;
  logic clr;
  logic [31:0] count;
  modport ctl (output clr, input count);
  modport tmr (input clr, output count);
endinterface : scd_tmr_if

/* File: scd_tick_timer.sv */
// prescaled 0.1 ms tick counter, held at zero while clr is high
// assumes clk_sys at the rate that TICK_CLKS was derived from
`timescale 1ns/100ps
module scd_tick_timer
  import scd_pkg::*;
#(
  parameter int unsigned TICK_CLKS_P = TICK_CLKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // timer port
  scd_tmr_if.tmr t
);
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [31:0] count;
  } scd_tmr_s;

  scd_tmr_s r;
  scd_tmr_s next_r;

  always_comb begin
    next_r = r;
    if (t.clr) begin
      next_r = '0; // RULE_14
    end else if (r.pre == PRE_W'(TICK_CLKS_P - 1)) begin
      next_r.pre = '0;
      if (r.count != DUR_MAX) begin
        next_r.count = r.count + 32'h00000001; // RULE_10
      end
    end else begin
      next_r.pre = r.pre + PRE_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign t.count = r.count;
endmodule : scd_tick_timer

/* File: scd_avg8.sv */
// running mean of the last eight recorded cycle durations
// assumes push is a one-cycle pulse with din already stable
`timescale 1ns/100ps
module scd_avg8
  import scd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // sample in, mean out
  input wire logic push,
  input wire logic [31:0] din,
  output logic [31:0] mean
);
  typedef struct packed {
    logic [AVG_DEPTH-1:0][31:0] hist;
    logic [31+AVG_SHIFT:0] sum;
  } scd_avg_s;

  scd_avg_s r;
  scd_avg_s next_r;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.sum = r.sum - (31+AVG_SHIFT+1)'(r.hist[AVG_DEPTH-1]) + (31+AVG_SHIFT+1)'(din); // RULE_11
      for (int i = AVG_DEPTH - 1; i > 0; i--) begin
        next_r.hist[i] = r.hist[i-1];
      end
      next_r.hist[0] = din;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign mean = r.sum[31+AVG_SHIFT:AVG_SHIFT];
endmodule : scd_avg8

/* File: tb_scd_supervisor.sv */
// self-checking bench for scd_supervisor, driven straight at its ports
// assumes scd_pkg is compiled first; a tick is shortened to 2 clocks
`timescale 1ns/100ps
module tb_scd_supervisor
  import scd_pkg::*;
;
  localparam int unsigned TCK = 2;
  typedef struct packed {logic [ADDR_W-1:0] addr; logic wr; logic [15:0] wd; logic [15:0] exp;} scd_row_s;
  localparam scd_row_s ROWS [9] = '{
    '{OFS_MIN_CYCLE, 1'b0, 16'h0000, 16'h0000}, '{OFS_WATCH, 1'b0, 16'h0000, 16'h0000},
    '{OFS_MIN_CYCLE, 1'b1, 16'h7D00, 16'h7D00}, '{OFS_MIN_CYCLE, 1'b1, 16'h0001, 16'h0001},
    '{OFS_WATCH, 1'b1, 16'h8FA0, 16'h8FA0}, '{OFS_WATCH, 1'b1, 16'h0000, 16'h0000},
    '{OFS_MAX_LO, 1'b1, 16'h1234, 16'h0000}, '{OFS_PRES_HI, 1'b1, 16'h5678, 16'h0000},
    '{9'h1FF, 1'b1, 16'hABCD, 16'h0000}};
  // inputs
  logic clk_sys, reset, ce, reg_wr, scan_done, parallel_mode, service_busy;
  logic [ADDR_W-1:0] reg_addr;
  logic [15:0] reg_wdata;
  // outputs
  logic [15:0] reg_rdata;
  logic scan_start, halt, cycle_overrun_flag, service_overrun_flag;
  int miscompares, samples_checked;
  logic [15:0] w;
  logic [31:0] d, p;
  int per;
  logic seen;

  scd_supervisor #(.TICK_CLKS_P(TCK)) i_scd_supervisor (.clk_sys(clk_sys), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .scan_done(scan_done), .parallel_mode(parallel_mode), .service_busy(service_busy),
    .scan_start(scan_start), .halt(halt), .cycle_overrun_flag(cycle_overrun_flag),
    .service_overrun_flag(service_overrun_flag));

  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic bad(input string msg);
    miscompares++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : bad

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("word %h expected %h", got, exp));
  endtask : chk_word

  task automatic chk_dur(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ((^got === 1'bx) || got < lo || got > hi) bad($sformatf("duration %0d outside %0d..%0d", got, lo, hi));
  endtask : chk_dur

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
  endtask : chk_flag

  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    v = reg_rdata;
  endtask : rd_reg

  task automatic rd32(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    rd_reg(a, v[15:0]);
    rd_reg(ADDR_W'(a + 1), v[31:16]);
  endtask : rd32

  // scan_start is sampled before the edge updates land
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (scan_start !== 1'b1 && n < 2000);
    if (scan_start !== 1'b1) begin
      bad("no scan start");
      wrap_up();
    end
  endtask : wait_start

  task automatic scan(input int dly, output int pr);
    int n;
    repeat (dly) @(posedge clk_sys);
    scan_done <= 1'b1;
    @(posedge clk_sys);
    scan_done <= 1'b0;
    wait_start(n);
    pr = dly + 1 + n;
  endtask : scan

  task automatic wait_flag(input logic svc, input int bound);
    int n;
    n = 0;
    while ((svc ? service_overrun_flag : cycle_overrun_flag) !== 1'b1 && n < bound) begin
      @(posedge clk_sys);
      n++;
    end
    chk_flag(svc ? service_overrun_flag : cycle_overrun_flag, 1'b1);
    chk_flag(halt, 1'b1);
    if ((svc ? service_overrun_flag : cycle_overrun_flag) !== 1'b1) wrap_up();
  endtask : wait_flag

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    bad("run timed out");
    wrap_up();
  end

  initial begin
    {reset, ce, reg_wr, scan_done, parallel_mode, service_busy} = 6'b110000;
    reg_addr = '0;
    reg_wdata = '0;
    miscompares = 0;
    samples_checked = 0;
    do_reset();
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wr_reg(ROWS[i].addr, ROWS[i].wd);
      rd_reg(ROWS[i].addr, w);
      chk_word(w, ROWS[i].exp);
    end
    // fixed period: minimum of 3 ms, short scans
    wr_reg(OFS_MIN_CYCLE, 16'h0003);
    scan(0, per);
    for (int i = 0; i < 9; i++) begin
      scan(5, per);
      if (i > 0) chk_dur(32'(per), 60, 64);
    end
    rd32(OFS_PRES_LO, d);
    chk_dur(d, 30, 30);
    rd32(OFS_MEAN_LO, d);
    chk_dur(d, 30, 30);
    // long scan gets no padding, then a short one keeps the maximum
    scan(200, per);
    chk_dur(32'(per), 200, 206);
    rd32(OFS_PRES_LO, p);
    chk_dur(p, 106, 108);
    rd32(OFS_MAX_LO, d);
    chk_dur(d, p, p);
    wr_reg(OFS_MIN_CYCLE, 16'h0000);
    scan(3, per);
    rd32(OFS_PRES_LO, d);
    chk_dur(d, 8, 10);
    rd32(OFS_MAX_LO, d);
    chk_dur(d, p, p);
    // parallel mode: execution time only, servicing recorded
    parallel_mode <= 1'b1;
    wr_reg(OFS_MIN_CYCLE, 16'h0003);
    scan(2, per);
    // clock enable low freezes the cycle timer, so the record below ignores these cycles
    ce <= 1'b0;
    repeat (40) @(posedge clk_sys);
    ce <= 1'b1;
    scan(20, per);
    chk_dur(32'(per), 60, 64);
    rd32(OFS_PRES_LO, d);
    chk_dur(d, 9, 13);
    service_busy <= 1'b1;
    repeat (100) @(posedge clk_sys);
    service_busy <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd32(OFS_SVC_LO, d);
    chk_dur(d, 48, 52);
    // programmed watch limit of 10 ms
    parallel_mode <= 1'b0;
    scan(2, per);
    wr_reg(OFS_WATCH, 16'h8001);
    repeat (180) @(posedge clk_sys);
    chk_flag(cycle_overrun_flag, 1'b0);
    wait_flag(1'b0, 40);
    seen = 1'b0;
    scan_done <= 1'b1;
    repeat (300) begin
      @(posedge clk_sys);
      scan_done <= 1'b0;
      if (scan_start === 1'b1 || cycle_overrun_flag !== 1'b1) seen = 1'b1;
    end
    chk_flag(seen, 1'b0);
    do_reset();
    @(posedge clk_sys);
    chk_flag(cycle_overrun_flag | halt, 1'b0);
    rd32(OFS_MAX_LO, d);
    chk_dur(d, 0, 0);
    // default 1 s watch limit
    repeat (19900) @(posedge clk_sys);
    chk_flag(cycle_overrun_flag, 1'b0);
    wait_flag(1'b0, 200);
    // servicing overrun at 2.0 s
    do_reset();
    wr_reg(OFS_WATCH, 16'h8FA0);
    service_busy <= 1'b1;
    repeat (39900) @(posedge clk_sys);
    chk_flag(service_overrun_flag, 1'b0);
    wait_flag(1'b1, 200);
    chk_flag(cycle_overrun_flag, 1'b0);
    wrap_up();
  end
endmodule : tb_scd_supervisor
